// File: src/smq_pkg.sv
// Purpose: Shared constants and carriers for the status message queues
// Assumes: AXI4-Lite register access with 32-bit data, one aligned word per register
// Notes:   Codes are 16-bit two's complement
package smq_pkg;
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  // Register byte addresses
  localparam logic [7:0] REG_STATUS    = 8'h00;
  localparam logic [7:0] REG_CTRL      = 8'h04;
  localparam logic [7:0] REG_RANGE     = 8'h08;
  localparam logic [7:0] REG_ERR_NEXT  = 8'h0c;
  localparam logic [7:0] REG_ERR_COUNT = 8'h10;
  localparam logic [7:0] REG_CODE_NEXT = 8'h14;
  localparam logic [7:0] REG_CODE_ALL  = 8'h18;
  localparam logic [7:0] REG_OUT_DATA  = 8'h1c;
  // Command bits in the control register (write pulses)
  localparam int CTL_QCLR   = 0;
  localparam int CTL_CLS    = 1;
  localparam int CTL_PRESET = 2;
  localparam int CTL_OPC    = 3;
  localparam int CTL_OPCQ   = 4;
  localparam int CTL_FBEGIN = 5;
  localparam int CTL_FADD   = 6;
  localparam int CTL_FREM   = 7;
  // Status register fields, then bits of the all-codes and output data words
  localparam int ST_EAV     = 0;
  localparam int ST_MAV     = 1;
  localparam int ST_OPC     = 2;
  localparam int ST_OQFULL  = 3;
  localparam int ST_CNT_LSB = 8;
  localparam int ALL_MORE_BIT  = 16;
  localparam int OUT_VALID_BIT = 8;
  // Queue shapes and special codes
  localparam int ERR_CODE_W = 16;
  localparam int EQ_DEPTH   = 10;
  localparam int OUTQ_W     = 8;
  localparam int OUTQ_DEPTH = 16;
  localparam logic [15:0] OVERFLOW_CODE = 16'h015e;
  localparam logic [15:0] NO_ERROR_CODE = 16'h0000;
  localparam logic [7:0]  OPC_REPLY     = 8'h31;
  // Filter window, values after reset and bus response codes
  localparam int   FILT_WIN_MIN = -512;
  localparam int   FILT_WIN_N   = 1536;
  localparam logic FILT_NEG_RST = 1'b1;
  localparam logic FILT_POS_RST = 1'b0;
  localparam logic [31:0] RANGE_RST = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic        valid;
    logic [15:0] code;
  } err_evt_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } resp_t;

  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
  } code_range_t;
endpackage

// File: src/msg_fifo.sv
// Purpose: Output message FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes:   Full and empty are exact; pop and push may share a cycle
`timescale 1ns/1ps
module msg_fifo #(
  parameter int WIDTH = smq_pkg::OUTQ_W,
  parameter int DEPTH = smq_pkg::OUTQ_DEPTH
) (
  input  wire logic             i_mclk,
  input  wire logic             i_srst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data,
  output logic                  o_full
);
  import smq_pkg::*;
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [CW-1:0]    count_reg;
  logic             push;
  logic             pop;

  // Handshakes taken from the occupancy only
  assign o_full      = (count_reg == CW'(DEPTH));
  assign o_in_ready  = !o_full;
  assign o_out_valid = (count_reg != '0);
  assign o_out_data  = mem[rd_ptr_reg];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = i_out_ready && o_out_valid;

  // Storage is not reset; only the pointers define what is valid
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end

  // Pointers wrap at DEPTH so non power-of-two depths work
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + CW'(push) - CW'(pop);
    end
  end
endmodule

// File: src/error_code_filter.sv
// Purpose: Per-code enable filter for the error queue
// Assumes: Range operations take one cycle each
// Notes:   Codes outside the window follow one flag per sign
`timescale 1ns/1ps
module error_code_filter #(
  parameter int WIN_MIN = smq_pkg::FILT_WIN_MIN,
  parameter int WIN_N   = smq_pkg::FILT_WIN_N
) (
  input  wire logic                i_mclk,
  input  wire logic                i_srst,
  input  wire logic                i_op_clear,
  input  wire logic                i_op_add,
  input  wire logic                i_op_remove,
  input  wire smq_pkg::code_range_t i_range,
  input  wire logic [15:0]         i_probe,
  output logic                     o_enabled
);
  import smq_pkg::*;
  localparam int IW = $clog2(WIN_N);

  logic [WIN_N-1:0]  en_reg;
  logic              out_neg_reg;
  logic              out_pos_reg;
  logic signed [31:0] lo;
  logic signed [31:0] hi;
  logic signed [31:0] a;
  logic signed [31:0] b;
  logic signed [31:0] d;

  // Either order of range ends is accepted
  assign a  = 32'(signed'(i_range.lo));
  assign b  = 32'(signed'(i_range.hi));
  assign lo = (a < b) ? a : b;
  assign hi = (a < b) ? b : a;

  // One enable bit per code; negative codes start enabled
  genvar gi;
  generate
    for (gi = 0; gi < WIN_N; gi++) begin : g_bit
      localparam logic signed [31:0] CODE = 32'(WIN_MIN + gi);
      logic in_r;
      assign in_r = (CODE >= lo) && (CODE <= hi);
      always_ff @(posedge i_mclk) begin
        if (i_srst) begin
          en_reg[gi] <= (CODE < 0) ? FILT_NEG_RST : FILT_POS_RST;
        end else if (i_op_clear) begin
          en_reg[gi] <= 1'b0;
        end else if (i_op_add && in_r) begin
          en_reg[gi] <= 1'b1;
        end else if (i_op_remove && in_r) begin
          en_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Outside flags clear on begin; add and remove move them only when a range reaches past that end
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      out_neg_reg <= FILT_NEG_RST;
      out_pos_reg <= FILT_POS_RST;
    end else if (i_op_clear) begin
      out_neg_reg <= 1'b0;
      out_pos_reg <= 1'b0;
    end else if (i_op_add || i_op_remove) begin
      if (lo < 32'(WIN_MIN)) begin
        out_neg_reg <= i_op_add;
      end
      if (hi >= 32'(WIN_MIN + WIN_N)) begin
        out_pos_reg <= i_op_add;
      end
    end
  end

  // Lookup of the incoming code
  assign d = 32'(signed'(i_probe)) - 32'(WIN_MIN);
  assign o_enabled = (d < 0)                ? out_neg_reg :
                     (d >= 32'(WIN_N))      ? out_pos_reg : en_reg[d[IW-1:0]];
endmodule

// File: src/status_message_queues.sv
// Purpose: Output queue and error queue of the status structure, AXI4-Lite slave
// Assumes: Events, responses and the idle level come from logic on i_mclk
// Notes:   Register reads of the queue words remove what they return
// Operation
// - Query responses enter the output queue; message-available shows while it holds data.
// - Reading a message from the output queue removes it.
// - Empty output queue clears message-available.
// - Enabled event pushes its code and sets error-available.
// - Empty error queue clears error-available.
// - Error queue stores at most ten messages.
// - Single read returns the oldest error entry, then removes it.
// - On filling, the last slot holds overflow code 350 instead.
// - Reading an empty error queue returns code 0.
// - Codes are signed: negative standard, positive vendor defined.
// - After reset: queue empty, error codes enabled, status codes disabled.
// - Filter commands name single codes or inclusive ranges, listed in turn.
// - Enable replaces the filter; unlisted codes become disabled. Here a range going below -512 or above 1023 enables all codes past that end.
// - Disable removes only the listed codes. Here a range going below -512 or above 1023 disables all codes past that end.
// - Enable with empty list blocks every message.
// - Count read returns held messages without removing any.
// - Code-only reads of oldest or all entries remove what they return.
// - Queue clear discards every error message.
// - Clear status empties the queue and resets events; preset leaves queue alone.
// - Filter survives clear status and preset.
// - Operation-complete query queues ASCII 1 once pending work finished.
// - Operation-complete command sets its bit only once idle.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module status_message_queues #(
  parameter int EQ_DEPTH_P   = smq_pkg::EQ_DEPTH,
  parameter int OUTQ_DEPTH_P = smq_pkg::OUTQ_DEPTH
) (
  input  wire logic                  i_mclk,
  input  wire logic                  i_srst,
  input  wire logic [7:0]            i_awaddr,
  input  wire logic                  i_awvalid,
  output logic                       o_awready,
  input  wire logic [31:0]           i_wdata,
  input  wire logic [3:0]            i_wstrb,
  input  wire logic                  i_wvalid,
  output logic                       o_wready,
  output logic [1:0]                 o_bresp,
  output logic                       o_bvalid,
  input  wire logic                  i_bready,
  input  wire logic [7:0]            i_araddr,
  input  wire logic                  i_arvalid,
  output logic                       o_arready,
  output logic [31:0]                o_rdata,
  output logic [1:0]                 o_rresp,
  output logic                       o_rvalid,
  input  wire logic                  i_rready,
  input  wire smq_pkg::err_evt_t     i_evt,
  input  wire smq_pkg::resp_t        i_resp,
  output logic                       o_resp_ready,
  input  wire logic                  i_inst_idle,
  output logic                       o_mav,
  output logic                       o_eav,
  output logic                       o_opc_event,
  output logic                       o_events_clear,
  output logic                       o_preset
);
  import smq_pkg::*;
  localparam int CW = $clog2(EQ_DEPTH_P + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(EQ_DEPTH_P);
  localparam logic [CW-1:0] LAST_IDX = CW'(EQ_DEPTH_P - 1);

  // Bus slave state
  logic [7:0]  aw_addr_reg;
  logic        aw_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        w_held_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        ar_hs;
  logic        wr_fire;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [7:0]  cmd;
  code_range_t range_reg;

  // Queue and flag state
  logic [15:0]   entries_reg [EQ_DEPTH_P];
  logic [CW-1:0] count_reg;
  logic [CW-1:0] base;
  logic          pop_err;
  logic          push_req;
  logic          clr_q;
  logic          filt_en;
  logic          opc_cmd_pend_reg;
  logic          opcq_pend_reg;
  logic          opc_event_reg;
  logic          events_clear_reg;
  logic          preset_reg;
  logic          oq_in_valid;
  logic [7:0]    oq_in_data;
  logic          oq_in_ready;
  logic          oq_out_valid;
  logic [7:0]    oq_out_data;
  logic          oq_full;
  logic          oq_pop;
  logic          opcq_push;

  // Address and data are taken in either order; the write fires when both are in
  assign o_awready = !aw_held_reg && !bvalid_reg;
  assign o_wready  = !w_held_reg && !bvalid_reg;
  assign wr_addr   = aw_held_reg ? aw_addr_reg : i_awaddr;
  assign wr_data   = w_held_reg ? w_data_reg : i_wdata;
  assign wr_strb   = w_held_reg ? w_strb_reg : i_wstrb;
  assign wr_fire   = !bvalid_reg && (aw_held_reg || i_awvalid) && (w_held_reg || i_wvalid);
  assign cmd       = (wr_fire && wr_addr == REG_CTRL && wr_strb[0]) ? wr_data[7:0] : 8'h00;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= i_wdata;
        w_strb_reg <= i_wstrb;
      end
    end
  end

  // Write response; unmapped or read-only addresses answer SLVERR
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (wr_addr == REG_CTRL || wr_addr == REG_RANGE) ? RESP_OKAY : RESP_SLVERR;
    end else if (i_bready) begin
      bvalid_reg <= 1'b0;
    end
  end
  assign o_bvalid = bvalid_reg;
  assign o_bresp  = bresp_reg;

  // Range register for filter commands, byte lanes honoured
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      range_reg <= RANGE_RST;
    end else if (wr_fire && wr_addr == REG_RANGE) begin
      for (int i = 0; i < 4; i++) begin
        if (wr_strb[i]) begin
          range_reg[8*i +: 8] <= wr_data[8*i +: 8];
        end
      end
    end
  end

  // Filter: begin clears, add and remove edit ranges; nothing else touches it
  error_code_filter #(
    .WIN_MIN (FILT_WIN_MIN),
    .WIN_N   (FILT_WIN_N)
  ) u_filter (
    .i_mclk      (i_mclk),
    .i_srst      (i_srst),
    .i_op_clear  (cmd[CTL_FBEGIN]),
    .i_op_add    (cmd[CTL_FADD]),
    .i_op_remove (cmd[CTL_FREM]),
    .i_range     (range_reg),
    .i_probe     (i_evt.code),
    .o_enabled   (filt_en)
  );

  // Read side: a pop happens on the address handshake, data one cycle later
  assign o_arready = !rvalid_reg;
  assign ar_hs     = i_arvalid && o_arready;
  assign pop_err   = ar_hs && (count_reg != '0) && (i_araddr == REG_ERR_NEXT ||
                     i_araddr == REG_CODE_NEXT || i_araddr == REG_CODE_ALL);
  assign oq_pop    = ar_hs && (i_araddr == REG_OUT_DATA);

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
      case (i_araddr)
        REG_STATUS: begin
          rdata_reg[ST_EAV]                 <= o_eav;
          rdata_reg[ST_MAV]                 <= o_mav;
          rdata_reg[ST_OPC]                 <= opc_event_reg;
          rdata_reg[ST_OQFULL]              <= oq_full;
          rdata_reg[ST_CNT_LSB +: CW]       <= count_reg;
        end
        REG_CTRL:      rdata_reg <= 32'h0000_0000;
        REG_RANGE:     rdata_reg <= range_reg;
        REG_ERR_COUNT: rdata_reg[CW-1:0] <= count_reg;
        REG_ERR_NEXT: begin
          // Empty queue gives the no-error code
          rdata_reg <= (count_reg != '0) ? 32'(signed'(entries_reg[0]))
                                         : 32'(signed'(NO_ERROR_CODE));
        end
        REG_CODE_NEXT: begin
          rdata_reg[15:0] <= (count_reg != '0) ? entries_reg[0] : NO_ERROR_CODE;
        end
        REG_CODE_ALL: begin
          // One code per beat; software repeats while the more bit is set
          rdata_reg[15:0]         <= (count_reg != '0) ? entries_reg[0] : NO_ERROR_CODE;
          rdata_reg[ALL_MORE_BIT] <= (count_reg > CW'(1));
        end
        REG_OUT_DATA: begin
          rdata_reg[7:0]           <= oq_out_valid ? oq_out_data : 8'h00;
          rdata_reg[OUT_VALID_BIT] <= oq_out_valid;
        end
        default: rresp_reg <= RESP_SLVERR;
      endcase
    end else if (i_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign o_rvalid = rvalid_reg;
  assign o_rdata  = rdata_reg;
  assign o_rresp  = rresp_reg;

  // Error queue: slot 0 is oldest; a clear and an event in one cycle keeps the event
  assign push_req = i_evt.valid && filt_en;
  assign clr_q    = cmd[CTL_QCLR] || cmd[CTL_CLS];
  assign base     = clr_q ? '0 : (count_reg - CW'(pop_err));

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      count_reg <= '0;
    end else if (push_req && base < LAST_IDX) begin
      count_reg <= base + 1'b1;
    end else if (push_req && base == LAST_IDX) begin
      count_reg <= FULL_CNT;
    end else begin
      count_reg <= base;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (pop_err && !clr_q) begin
      for (int i = 0; i < EQ_DEPTH_P - 1; i++) begin
        entries_reg[i] <= entries_reg[i+1];
      end
    end
    if (push_req && base < LAST_IDX) begin
      entries_reg[base] <= i_evt.code;
    end else if (push_req && base == LAST_IDX) begin
      entries_reg[base] <= OVERFLOW_CODE;
    end
  end
  assign o_eav = (count_reg != '0);

  // Operation complete: both forms wait until the instrument is idle
  assign opcq_push = opcq_pend_reg && i_inst_idle && !i_resp.valid && oq_in_ready;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      opc_cmd_pend_reg <= 1'b0;
      opcq_pend_reg    <= 1'b0;
      opc_event_reg    <= 1'b0;
    end else begin
      if (cmd[CTL_OPC]) begin
        opc_cmd_pend_reg <= 1'b1;
      end else if (i_inst_idle) begin
        opc_cmd_pend_reg <= 1'b0;
      end
      if (cmd[CTL_OPCQ]) begin
        opcq_pend_reg <= 1'b1;
      end else if (opcq_push) begin
        opcq_pend_reg <= 1'b0;
      end
      // Setting beats a clear-status in the same cycle
      if (opc_cmd_pend_reg && i_inst_idle) begin
        opc_event_reg <= 1'b1;
      end else if (cmd[CTL_CLS]) begin
        opc_event_reg <= 1'b0;
      end
    end
  end

  // One-cycle pulses to the other event registers
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      events_clear_reg <= 1'b0;
      preset_reg       <= 1'b0;
    end else begin
      events_clear_reg <= cmd[CTL_CLS];
      preset_reg       <= cmd[CTL_PRESET];
    end
  end
  assign o_opc_event    = opc_event_reg;
  assign o_events_clear = events_clear_reg;
  assign o_preset       = preset_reg;

  // Output queue; responses win the input, the reply char waits for a cycle with no response
  assign oq_in_valid  = i_resp.valid || opcq_push;
  assign oq_in_data   = i_resp.valid ? i_resp.data : OPC_REPLY;
  assign o_resp_ready = oq_in_ready;

  msg_fifo #(
    .WIDTH (OUTQ_W),
    .DEPTH (OUTQ_DEPTH_P)
  ) u_outq (
    .i_mclk      (i_mclk),
    .i_srst      (i_srst),
    .i_in_valid  (oq_in_valid),
    .o_in_ready  (oq_in_ready),
    .i_in_data   (oq_in_data),
    .o_out_valid (oq_out_valid),
    .i_out_ready (oq_pop),
    .o_out_data  (oq_out_data),
    .o_full      (oq_full)
  );
  assign o_mav = oq_out_valid;

  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  sequence s_read_err_next;
    ar_hs && i_araddr == REG_ERR_NEXT;
  endsequence
  sequence s_data_out;
    ##1 o_rvalid;
  endsequence

  a_count_bound: assert property (count_reg <= FULL_CNT)
    else $error("error queue count above depth");
  a_eav_empty: assert property (pop_err && count_reg == CW'(1) && !push_req |=> !o_eav)
    else $error("error available still set after last entry read");
  a_push_sets_eav: assert property (push_req && !clr_q |=> o_eav)
    else $error("enabled event did not set error available");
  a_oldest_read: assert property (s_read_err_next and count_reg != '0
    |-> s_data_out ##0 (o_rdata[15:0] == $past(entries_reg[0])))
    else $error("next read did not return oldest entry");
  a_empty_read: assert property (s_read_err_next and count_reg == '0
    |-> s_data_out ##0 (o_rdata == 32'h0000_0000))
    else $error("empty queue read not zero");
  a_overflow_slot: assert property (push_req && base == LAST_IDX
    |=> entries_reg[EQ_DEPTH_P-1] == OVERFLOW_CODE && count_reg == FULL_CNT)
    else $error("overflow code missing in last slot");
  a_full_drop: assert property (count_reg == FULL_CNT && !pop_err && !clr_q
    |=> count_reg == FULL_CNT && $stable(entries_reg[EQ_DEPTH_P-1]))
    else $error("full queue changed without read or clear");
  a_clear_empties: assert property (clr_q && !push_req |=> count_reg == '0)
    else $error("clear left messages in queue");
  a_count_no_pop: assert property (ar_hs && i_araddr == REG_ERR_COUNT
    && !push_req && !clr_q |=> $stable(count_reg))
    else $error("count read changed the queue");
  a_opc_idle: assert property ($rose(opc_event_reg) |-> $past(i_inst_idle))
    else $error("operation complete set while busy");
  a_opcq_char: assert property (opcq_push |-> oq_in_valid && oq_in_data == OPC_REPLY ##1 o_mav)
    else $error("operation complete reply not queued");
  a_mav_empty: assert property (oq_pop && u_outq.count_reg == 1 && !oq_in_valid |=> !o_mav)
    else $error("message available set with empty queue");
endmodule

// File: verification/smq_host.sv
// Purpose: Bus controller model that drives the AXI4-Lite slave
// Assumes: Ready and valid have settled by the falling edge
// Notes:   The bench calls wr and rd; hung counts waits that ran out
`timescale 1ns/1ps
module smq_host (
  input  wire logic        i_mclk,
  output logic [7:0]       i_awaddr,
  output logic             i_awvalid,
  input  wire logic        o_awready,
  output logic [31:0]      i_wdata,
  output logic [3:0]       i_wstrb,
  output logic             i_wvalid,
  input  wire logic        o_wready,
  input  wire logic [1:0]  o_bresp,
  input  wire logic        o_bvalid,
  output logic             i_bready,
  output logic [7:0]       i_araddr,
  output logic             i_arvalid,
  input  wire logic        o_arready,
  input  wire logic [31:0] o_rdata,
  input  wire logic [1:0]  o_rresp,
  input  wire logic        o_rvalid,
  output logic             i_rready
);
  int   hung = 0;
  logic ta, tw, tb;
  logic [1:0] bresp_seen;
  initial begin
    {i_awaddr, i_awvalid, i_wdata, i_wstrb, i_wvalid, i_bready} = '0;
    {i_araddr, i_arvalid, i_rready} = '0;
  end
  // Address and data rise together; each drops once taken, and both address and data are scrambled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_mclk);
    {i_awaddr, i_wdata, i_wstrb, i_awvalid, i_wvalid, i_bready} <= {a, d, 4'hf, 3'h7};
    for (n = 0; n < 50; n++) begin
      @(negedge i_mclk);
      {ta, tw, tb, bresp_seen} = {i_awvalid & o_awready, i_wvalid & o_wready, o_bvalid, o_bresp};
      @(posedge i_mclk);
      if (ta) {i_awvalid, i_awaddr} <= {1'b0, ~a};
      if (tw) {i_wvalid, i_wdata} <= {1'b0, ~d};
      if (tb) break;
    end
    i_bready <= 1'b0;
    hung += (n == 50);
  endtask
  // Read data is taken in the cycle that rvalid is seen, then rready drops
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge i_mclk);
    {i_araddr, i_arvalid, i_rready} <= {a, 2'h3};
    for (n = 0; n < 50; n++) begin
      @(negedge i_mclk);
      {ta, tb, d, r} = {i_arvalid & o_arready, o_rvalid, o_rdata, o_rresp};
      @(posedge i_mclk);
      if (ta) {i_arvalid, i_araddr} <= {1'b0, ~a};
      if (tb) break;
    end
    i_rready <= 1'b0;
    hung += (n == 50);
  endtask
endmodule

// File: verification/status_message_queues_tb.sv
// Purpose: Self-checking bench for the status message queues
// Assumes: smq_host drives the register bus
// Notes:   Fixed settling waits stay short
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_count++; \
  $display("FAIL %s exp %h got %h", n, e, s); end end
module status_message_queues_tb;
  import smq_pkg::*;
  logic        i_mclk, i_srst, i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready;
  logic        i_arvalid, o_arready, o_rvalid, i_rready, o_resp_ready, i_inst_idle, o_mav;
  logic        o_eav, o_opc_event, o_events_clear, o_preset;
  logic [7:0]  i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, rv;
  logic [3:0]  i_wstrb;
  logic [1:0]  o_bresp, o_rresp, rr;
  err_evt_t    i_evt;
  resp_t       i_resp;
  int          err_count = 0, num_checks = 0, k, n_ecl = 0, n_pre = 0;
  initial i_mclk = 1'b0;
  always #10 i_mclk = ~i_mclk;
  // Count the one-cycle pulses to the other event registers; skipped in reset
  always @(posedge i_mclk) begin
    if (!i_srst) begin
      n_ecl <= n_ecl + int'(o_events_clear);
      n_pre <= n_pre + int'(o_preset);
    end
  end
  status_message_queues i_status_message_queues (.i_mclk, .i_srst, .i_awaddr, .i_awvalid,
    .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
    .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_evt,
    .i_resp, .o_resp_ready, .i_inst_idle, .o_mav, .o_eav, .o_opc_event, .o_events_clear,
    .o_preset);
  smq_host i_smq_host (.i_mclk, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
    .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
    .o_rresp, .o_rvalid, .i_rready);
  task automatic ck_rd(input logic [7:0] a, input logic [31:0] e);
    i_smq_host.rd(a, rv, rr);
    `CHK($sformatf("reg %h", a), e, rv)
  endtask
  // One-cycle event pulse, with an idle cycle so pulses never merge
  task automatic ev(input logic [15:0] c);
    @(posedge i_mclk);
    i_evt <= '{1'b1, c};
    @(posedge i_mclk);
    i_evt <= '0;
  endtask
  task automatic wc(input logic [31:0] d);
    i_smq_host.wr(REG_CTRL, d);
  endtask
  task summarize;
    err_count += i_smq_host.hung;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #2000000;
    err_count++;
    summarize;
  end
  initial begin
    {i_srst, i_inst_idle, i_evt, i_resp} = {1'b1, 27'h0};
    repeat (10) @(posedge i_mclk);
    i_srst <= 1'b0;
    ck_rd(REG_STATUS, 32'h0);
    ck_rd(REG_ERR_NEXT, 32'h0);
    ev(16'h0005);
    for (k = 1; k <= 12; k++) ev(16'(-k));
    ck_rd(REG_ERR_COUNT, 32'ha);
    `CHK("eav", 1'b1, o_eav)
    for (k = 1; k <= 9; k++) ck_rd(REG_ERR_NEXT, 32'(-k));
    ck_rd(REG_ERR_NEXT, 32'h15e);
    `CHK("eav", 1'b0, o_eav)
    i_smq_host.wr(REG_RANGE, 32'h0005_0003);
    wc(32'h20);
    wc(32'h40);
    ev(16'h0004);
    ev(16'hffff);
    ck_rd(REG_ERR_COUNT, 32'h1);
    i_smq_host.wr(REG_RANGE, 32'h0004_0004);
    wc(32'h80);
    ev(16'h0004);
    ev(16'h0005);
    ck_rd(REG_CODE_NEXT, 32'h4);
    ck_rd(REG_CODE_ALL, 32'h5);
    ev(16'h0003);
    wc(32'h02);
    ck_rd(REG_ERR_COUNT, 32'h0);
    `CHK("ecl", 1, n_ecl)
    ev(16'h0003);
    wc(32'h04);
    ck_rd(REG_ERR_COUNT, 32'h1);
    `CHK("pre", 1, n_pre)
    wc(32'h01);
    ck_rd(REG_ERR_COUNT, 32'h0);
    wc(32'h20);
    ev(16'h0003);
    ev(16'hffff);
    ck_rd(REG_ERR_COUNT, 32'h0);
    `CHK("rdy", 1'b1, o_resp_ready)
    @(posedge i_mclk);
    i_resp <= '{1'b1, 8'h41};
    @(posedge i_mclk);
    i_resp <= '0;
    @(posedge i_mclk);
    `CHK("mav", 1'b1, o_mav)
    ck_rd(REG_OUT_DATA, 32'h141);
    `CHK("mav", 1'b0, o_mav)
    wc(32'h18);
    repeat (5) @(posedge i_mclk);
    `CHK("mav", 1'b0, o_mav)
    `CHK("opc", 1'b0, o_opc_event)
    i_inst_idle <= 1'b1;
    repeat (5) @(posedge i_mclk);
    `CHK("opc", 1'b1, o_opc_event)
    ck_rd(REG_OUT_DATA, 32'h131);
    i_smq_host.wr(REG_ERR_COUNT, 32'h1);
    `CHK("bresp", RESP_SLVERR, i_smq_host.bresp_seen)
    ck_rd(8'h20, 32'h0);
    `CHK("rresp", RESP_SLVERR, rr)
    summarize;
  end
endmodule
